// *** design/irqw_pkg.sv ***
// Constants for the interrupt request and wake logic
// Operation
// - Set the EEPROM done flag when a nonvolatile write cycle finishes.
// - Vector EEPROM only with global and EEPROM enables set, stack not full.
// - Servicing EEPROM clears the global enable and the EEPROM done flag.
// - Each timer has compare P and compare A flags, each with an enable.
// - Timer vectors need global, timer and group enables, stack not full.
// - Servicing a timer clears global enable and group flag, not timer flags.
// - Any request flag rising wakes from sleep or idle, whatever the enables.
// - Flags stay set until serviced or cleared; enables only block service.
// - Interrupt entry pushes only the program counter.
// - Interrupt return pops the program counter and sets the global enable.
// - Subroutine return pops the program counter, global enable unchanged.
// - A group flag sets when any timer flag of that group becomes set.
// - Accepting an interrupt loads the program counter with its vector.
package irqw_pkg;

    // --------------------------------------------------
    // Widths
    // --------------------------------------------------
    localparam int DW  = 8;
    localparam int AW  = 3;
    localparam int PCW = 12;

    // --------------------------------------------------
    // Register offsets
    // --------------------------------------------------
    localparam logic [AW-1:0] REG_CTRL  = 3'h0;
    localparam logic [AW-1:0] REG_TEN   = 3'h1;
    localparam logic [AW-1:0] REG_FLAG  = 3'h2;
    localparam logic [AW-1:0] REG_TFLAG = 3'h3;
    localparam logic [AW-1:0] REG_EVT   = 3'h4;
    localparam logic [AW-1:0] REG_MASK  = 3'h5;

    // --------------------------------------------------
    // Field positions
    // --------------------------------------------------
    localparam int CTRL_GIE  = 0;
    localparam int CTRL_EEE  = 1;
    localparam int CTRL_GRP  = 2;
    localparam int FLAG_EED  = 0;
    localparam int FLAG_GRP  = 1;
    localparam int EVT_WAKE  = 0;
    localparam int EVT_TAKE  = 1;

    // --------------------------------------------------
    // Reset values
    // --------------------------------------------------
    localparam logic [DW-1:0] CTRL_RST  = 8'h00;
    localparam logic [DW-1:0] TEN_RST   = 8'h00;
    localparam logic [DW-1:0] FLAG_RST  = 8'h00;
    localparam logic [DW-1:0] TFLAG_RST = 8'h00;
    localparam logic [DW-1:0] EVT_RST   = 8'h00;
    localparam logic [DW-1:0] MASK_RST  = 8'h00;

    // --------------------------------------------------
    // Vectors
    // --------------------------------------------------
    localparam logic [PCW-1:0] VEC_EEPROM = 12'h004;
    localparam logic [PCW-1:0] VEC_GROUP0 = 12'h008;
    localparam logic [PCW-1:0] VEC_STEP   = 12'h004;

    // --------------------------------------------------
    // Accepted source
    // --------------------------------------------------
    typedef enum logic [1:0] {
        SRC_NONE   = 2'b00,
        SRC_EEPROM = 2'b01,
        SRC_GROUP  = 2'b10
    } irqw_src_t;

endpackage

// *** design/irqw_ctrl.sv ***
// Interrupt request, acknowledge and wake logic
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module irqw_ctrl #(
    parameter int N_TIMERS = 2
) (
    // Clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        arst_n,
    // Register port
    input  wire logic [irqw_pkg::AW-1:0]     reg_addr,
    input  wire logic [irqw_pkg::DW-1:0]     reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [irqw_pkg::DW-1:0]     reg_rdata,
    // Request sources
    input  wire logic                        eeprom_write_done,
    input  wire logic [N_TIMERS-1:0]         timer_cmp_p_match,
    input  wire logic [N_TIMERS-1:0]         timer_cmp_a_match,
    // CPU sequencer
    input  wire logic                        int_slot,
    input  wire logic                        stack_full,
    input  wire logic [irqw_pkg::PCW-1:0]    pc_current,
    input  wire logic                        isr_exit_instr,
    input  wire logic                        subroutine_exit_instr,
    input  wire logic                        low_power,
    output logic                             int_take,
    output logic      [irqw_pkg::PCW-1:0]    int_vector,
    output logic                             stack_push,
    output logic      [irqw_pkg::PCW-1:0]    stack_push_pc,
    output logic                             stack_pop,
    output logic                             global_int_enable,
    output logic                             wake_req,
    output logic                             irq
);

    // --------------------------------------------------
    // Storage
    // --------------------------------------------------
    localparam int TW = 2 * N_TIMERS;

    logic [irqw_pkg::DW-1:0] ctrl;
    logic [TW-1:0]           ten;
    logic                    eeprom_done_flag;
    logic [N_TIMERS-1:0]     group_request_flags;
    logic [TW-1:0]           tflag;
    logic [1:0]              evt;
    logic [1:0]              mask;

    logic                    next_eed;
    logic [TW-1:0]           next_tflag;
    logic [N_TIMERS-1:0]     next_grp;
    logic [1:0]              next_evt;
    logic [N_TIMERS-1:0]     grp_pend;
    logic [N_TIMERS-1:0]     grp_take;
    logic [N_TIMERS-1:0]     grp_en;
    logic                    eed_pend;
    logic                    go;
    logic                    rise_any;
    irqw_pkg::irqw_src_t     src;
    logic [irqw_pkg::PCW-1:0] vec;
    logic [irqw_pkg::DW-1:0] rd_mux;

    logic wr_ctrl;
    logic wr_ten;
    logic wr_flag;
    logic wr_tflag;
    logic wr_mask;
    logic rd_evt;

    // Timer i owns flag bits 2i (compare P) and 2i+1 (compare A)
    function automatic logic pair_req(input logic [TW-1:0] f,
                                      input logic [TW-1:0] e,
                                      input int            i);
        pair_req = (f[2*i] & e[2*i]) | (f[2*i+1] & e[2*i+1]);
    endfunction

    // --------------------------------------------------
    // Decode
    // --------------------------------------------------
    assign wr_ctrl  = reg_wr && (reg_addr == irqw_pkg::REG_CTRL);
    assign wr_ten   = reg_wr && (reg_addr == irqw_pkg::REG_TEN);
    assign wr_flag  = reg_wr && (reg_addr == irqw_pkg::REG_FLAG);
    assign wr_tflag = reg_wr && (reg_addr == irqw_pkg::REG_TFLAG);
    assign wr_mask  = reg_wr && (reg_addr == irqw_pkg::REG_MASK);
    assign rd_evt   = reg_rd && (reg_addr == irqw_pkg::REG_EVT);

    // --------------------------------------------------
    // Pending and priority
    // --------------------------------------------------
    assign grp_en   = ctrl[irqw_pkg::CTRL_GRP +: N_TIMERS];
    assign eed_pend = eeprom_done_flag & ctrl[irqw_pkg::CTRL_EEE];

    always_comb begin
        for (int g = 0; g < N_TIMERS; g++) begin
            grp_pend[g] = group_request_flags[g] & grp_en[g]
                        & pair_req(tflag, ten, g);
        end
    end

    assign go = int_slot & global_int_enable & ~stack_full
              & (eed_pend | (|grp_pend));

    always_comb begin
        src      = irqw_pkg::SRC_NONE;
        vec      = irqw_pkg::VEC_EEPROM;
        grp_take = '0;
        if (eed_pend) begin
            src = irqw_pkg::SRC_EEPROM;
        end else begin
            for (int g = N_TIMERS - 1; g >= 0; g--) begin
                if (grp_pend[g]) begin
                    src      = irqw_pkg::SRC_GROUP;
                    grp_take = N_TIMERS'(1) << g;
                    vec      = irqw_pkg::VEC_GROUP0
                             + 12'(g) * irqw_pkg::VEC_STEP;
                end
            end
        end
    end

    // --------------------------------------------------
    // Flag next values
    // --------------------------------------------------
    always_comb begin
        next_eed = eeprom_done_flag;
        if (go && src == irqw_pkg::SRC_EEPROM) begin
            next_eed = 1'b0;
        end
        if (wr_flag) begin
            next_eed = reg_wdata[irqw_pkg::FLAG_EED];
        end
        if (eeprom_write_done) begin
            next_eed = 1'b1;
        end
    end

    always_comb begin
        next_tflag = tflag;
        if (wr_tflag) begin
            next_tflag = reg_wdata[TW-1:0];
        end
        for (int t = 0; t < N_TIMERS; t++) begin
            if (timer_cmp_p_match[t]) begin
                next_tflag[2*t] = 1'b1;
            end
            if (timer_cmp_a_match[t]) begin
                next_tflag[2*t+1] = 1'b1;
            end
        end
    end

    always_comb begin
        next_grp = group_request_flags;
        if (go && src == irqw_pkg::SRC_GROUP) begin
            next_grp = next_grp & ~grp_take;
        end
        if (wr_flag) begin
            next_grp = reg_wdata[irqw_pkg::FLAG_GRP +: N_TIMERS];
        end
        for (int g = 0; g < N_TIMERS; g++) begin
            if (|(next_tflag[2*g +: 2] & ~tflag[2*g +: 2])) begin
                next_grp[g] = 1'b1;
            end
        end
    end

    assign rise_any = (next_eed & ~eeprom_done_flag)
                    | (|(next_tflag & ~tflag))
                    | (|(next_grp & ~group_request_flags));

    always_comb begin
        next_evt = rd_evt ? 2'b00 : evt;
        if (rise_any && low_power) begin
            next_evt[irqw_pkg::EVT_WAKE] = 1'b1;
        end
        if (go) begin
            next_evt[irqw_pkg::EVT_TAKE] = 1'b1;
        end
    end

    // --------------------------------------------------
    // Flags
    // --------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            eeprom_done_flag    <= irqw_pkg::FLAG_RST[irqw_pkg::FLAG_EED];
            group_request_flags <= '0;
            tflag               <= '0;
        end else begin
            eeprom_done_flag    <= next_eed;
            group_request_flags <= next_grp;
            tflag               <= next_tflag;
        end
    end

    // --------------------------------------------------
    // Control registers
    // --------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl <= irqw_pkg::CTRL_RST;
            ten  <= irqw_pkg::TEN_RST[TW-1:0];
            mask <= irqw_pkg::MASK_RST[1:0];
        end else begin
            if (wr_ctrl) begin
                ctrl <= reg_wdata;
            end
            if (wr_ten) begin
                ten <= reg_wdata[TW-1:0];
            end
            if (wr_mask) begin
                mask <= reg_wdata[1:0];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            global_int_enable <= irqw_pkg::CTRL_RST[irqw_pkg::CTRL_GIE];
        end else if (go) begin
            global_int_enable <= 1'b0;
        end else if (isr_exit_instr) begin
            global_int_enable <= 1'b1;
        end else if (wr_ctrl) begin
            global_int_enable <= reg_wdata[irqw_pkg::CTRL_GIE];
        end
    end

    // --------------------------------------------------
    // CPU handshake
    // --------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            int_take      <= 1'b0;
            int_vector    <= '0;
            stack_push    <= 1'b0;
            stack_push_pc <= '0;
            stack_pop     <= 1'b0;
        end else begin
            int_take      <= go;
            stack_push    <= go;
            stack_pop     <= isr_exit_instr | subroutine_exit_instr;
            if (go) begin
                int_vector    <= vec;
                stack_push_pc <= pc_current;
            end
        end
    end

    // --------------------------------------------------
    // Wake and interrupt status
    // --------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wake_req <= 1'b0;
            evt      <= irqw_pkg::EVT_RST[1:0];
            irq      <= 1'b0;
        end else begin
            wake_req <= rise_any & low_power;
            evt      <= next_evt;
            irq      <= |(next_evt & mask);
        end
    end

    // --------------------------------------------------
    // Read port
    // --------------------------------------------------
    always_comb begin
        rd_mux = '0;
        case (reg_addr)
            irqw_pkg::REG_CTRL: begin
                rd_mux = ctrl;
                rd_mux[irqw_pkg::CTRL_GIE] = global_int_enable;
            end
            irqw_pkg::REG_TEN: begin
                rd_mux[TW-1:0] = ten;
            end
            irqw_pkg::REG_FLAG: begin
                rd_mux[irqw_pkg::FLAG_EED] = eeprom_done_flag;
                rd_mux[irqw_pkg::FLAG_GRP +: N_TIMERS] = group_request_flags;
            end
            irqw_pkg::REG_TFLAG: begin
                rd_mux[TW-1:0] = tflag;
            end
            irqw_pkg::REG_EVT: begin
                rd_mux[1:0] = evt;
            end
            irqw_pkg::REG_MASK: begin
                rd_mux[1:0] = mask;
            end
            default: begin
                rd_mux = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : '0;
        end
    end

endmodule
`default_nettype wire

// *** bench/irqw_ctrl_checker.sv ***
// Concurrent checks on the ports of the interrupt request and wake logic
`timescale 1ns/1ps
`default_nettype none
module irqw_ctrl_checker #(
    parameter int N_TIMERS = 2
) (
    // Clock, reset and register port
    input wire logic                     sys_clk,
    input wire logic                     arst_n,
    input wire logic                     reg_wr,
    // Sources
    input wire logic                     eeprom_write_done,
    input wire logic [N_TIMERS-1:0]      timer_cmp_p_match,
    input wire logic [N_TIMERS-1:0]      timer_cmp_a_match,
    // Sequencer
    input wire logic                     int_slot,
    input wire logic                     stack_full,
    input wire logic [irqw_pkg::PCW-1:0] pc_current,
    input wire logic                     isr_exit_instr,
    input wire logic                     subroutine_exit_instr,
    input wire logic                     low_power,
    input wire logic                     int_take,
    input wire logic [irqw_pkg::PCW-1:0] int_vector,
    input wire logic                     stack_push,
    input wire logic [irqw_pkg::PCW-1:0] stack_push_pc,
    input wire logic                     stack_pop,
    input wire logic                     global_int_enable,
    input wire logic                     wake_req
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    take_gie_clr_a: assert property (int_take |-> !global_int_enable)
        else $error("global enable kept after acceptance");
    take_cause_a: assert property (
        int_take |-> $past(int_slot && global_int_enable && !stack_full))
        else $error("acceptance without slot, enable or stack room");
    push_pc_a: assert property (
        int_take |-> stack_push && stack_push_pc == $past(pc_current))
        else $error("push missing or wrong saved counter");
    take_vec_a: assert property (int_take |->
        int_vector == irqw_pkg::VEC_EEPROM || (int_vector[1:0] == 2'h0 &&
        int_vector >= irqw_pkg::VEC_GROUP0 &&
        int_vector < irqw_pkg::VEC_GROUP0 + 12'(4 * N_TIMERS)))
        else $error("vector outside the source table");
    one_take_a: assert property (int_take |=> !int_take)
        else $error("two acceptances in a row");
    isr_exit_gie_a: assert property (
        isr_exit_instr && !int_slot && !reg_wr |=> stack_pop && global_int_enable)
        else $error("interrupt return left enable low or no pop");
    sub_exit_keep_a: assert property (subroutine_exit_instr && !isr_exit_instr &&
        !int_slot && !reg_wr |=> stack_pop && $stable(global_int_enable))
        else $error("plain return changed the enable or no pop");
    pop_cause_a: assert property (
        stack_pop |-> $past(isr_exit_instr || subroutine_exit_instr))
        else $error("pop without a return");
    wake_cause_a: assert property (wake_req |-> $past(low_power &&
        (eeprom_write_done || |timer_cmp_p_match || |timer_cmp_a_match || reg_wr)))
        else $error("wake without a rising flag in low power");

    take_c: cover property (int_take);
    wake_c: cover property (wake_req);
    full_c: cover property (int_slot && stack_full && global_int_enable);
endmodule
bind irqw_ctrl irqw_ctrl_checker #(.N_TIMERS(N_TIMERS)) u_chk (
    .sys_clk               (sys_clk),
    .arst_n                (arst_n),
    .reg_wr                (reg_wr),
    .eeprom_write_done     (eeprom_write_done),
    .timer_cmp_p_match     (timer_cmp_p_match),
    .timer_cmp_a_match     (timer_cmp_a_match),
    .int_slot              (int_slot),
    .stack_full            (stack_full),
    .pc_current            (pc_current),
    .isr_exit_instr        (isr_exit_instr),
    .subroutine_exit_instr (subroutine_exit_instr),
    .low_power             (low_power),
    .int_take              (int_take),
    .int_vector            (int_vector),
    .stack_push            (stack_push),
    .stack_push_pc         (stack_push_pc),
    .stack_pop             (stack_pop),
    .global_int_enable     (global_int_enable),
    .wake_req              (wake_req)
);
`default_nettype wire

// *** bench/irqw_cpu_model.sv ***
// Sequencer stand-in: program counter and return stack depth
`timescale 1ns/1ps
`default_nettype none
module irqw_cpu_model #(
    parameter int DEPTH = 1
) (
    // Clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     arst_n,
    // Stack strobes
    input  wire logic                     stack_push,
    input  wire logic                     stack_pop,
    // Sequencer state
    output logic                          stack_full,
    output logic      [irqw_pkg::PCW-1:0] pc_current
);
    int depth;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            depth      <= 0;
            pc_current <= 12'h100;
        end else begin
            depth      <= depth + int'(stack_push) - int'(stack_pop);
            pc_current <= pc_current + 12'h001;
        end
    end

    assign stack_full = (depth >= DEPTH);
endmodule
`default_nettype wire

// *** bench/tb_irqw_ctrl.sv ***
// Testbench for the interrupt request and wake logic
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, g) begin compares++; if ((g) !== (e)) begin \
    $display("[FAIL] %s exp %h got %h", n, e, g); bad_count++; end end
module tb_irqw_ctrl;
    logic        sys_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [2:0]  reg_addr = 3'h0;
    logic [7:0]  reg_wdata = 8'h00, reg_rdata;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, low_power = 1'b0;
    logic        eeprom_write_done = 1'b0, int_slot = 1'b0, stack_full;
    logic [1:0]  timer_cmp_p_match = 2'h0, timer_cmp_a_match = 2'h0;
    logic        isr_exit_instr = 1'b0, subroutine_exit_instr = 1'b0;
    logic [11:0] pc_current, int_vector, stack_push_pc;
    logic        int_take, stack_push, stack_pop, global_int_enable, wake_req, irq;
    int          bad_count = 0;
    int          compares = 0;

    always #2 sys_clk = ~sys_clk;

    irqw_ctrl #(.N_TIMERS(2)) uut (
        .sys_clk               (sys_clk),
        .arst_n                (arst_n),
        .reg_addr              (reg_addr),
        .reg_wdata             (reg_wdata),
        .reg_wr                (reg_wr),
        .reg_rd                (reg_rd),
        .reg_rdata             (reg_rdata),
        .eeprom_write_done     (eeprom_write_done),
        .timer_cmp_p_match     (timer_cmp_p_match),
        .timer_cmp_a_match     (timer_cmp_a_match),
        .int_slot              (int_slot),
        .stack_full            (stack_full),
        .pc_current            (pc_current),
        .isr_exit_instr        (isr_exit_instr),
        .subroutine_exit_instr (subroutine_exit_instr),
        .low_power             (low_power),
        .int_take              (int_take),
        .int_vector            (int_vector),
        .stack_push            (stack_push),
        .stack_push_pc         (stack_push_pc),
        .stack_pop             (stack_pop),
        .global_int_enable     (global_int_enable),
        .wake_req              (wake_req),
        .irq                   (irq)
    );
    irqw_cpu_model #(.DEPTH(1)) cpu (.sys_clk(sys_clk), .arst_n(arst_n),
        .stack_push(stack_push), .stack_pop(stack_pop),
        .stack_full(stack_full), .pc_current(pc_current));

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1 `CK("rdata", e, reg_rdata)
    endtask

    // Mask: done, p[1:0], a[1:0], slot, isr exit, plain exit
    // Expect: take, pop, global enable, wake
    task automatic pulse(input logic [7:0] m, input logic [3:0] e);
        @(posedge sys_clk);
        {eeprom_write_done, timer_cmp_p_match, timer_cmp_a_match,
            int_slot, isr_exit_instr, subroutine_exit_instr} <= m;
        @(posedge sys_clk);
        {eeprom_write_done, timer_cmp_p_match, timer_cmp_a_match,
            int_slot, isr_exit_instr, subroutine_exit_instr} <= 8'h00;
        #1 `CK("strobes", e, {int_take, stack_pop, global_int_enable, wake_req})
    endtask

    task automatic stop_test();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (2000) @(posedge sys_clk);
        bad_count++;
        stop_test();
    end

    initial begin
        repeat (12) @(posedge sys_clk);
        arst_n <= 1'b1;
        for (int a = 0; a < 8; a++) rd(3'(a), 8'h00);
        wr(irqw_pkg::REG_MASK, 8'h03);
        @(posedge sys_clk) low_power <= 1'b1;
        pulse(8'h80, 4'h1);
        `CK("irq", 1'b1, irq)
        rd(irqw_pkg::REG_FLAG, 8'h01);
        rd(irqw_pkg::REG_EVT, 8'h01);
        `CK("irq", 1'b0, irq)
        @(posedge sys_clk) low_power <= 1'b0;
        wr(irqw_pkg::REG_CTRL, 8'h03);
        pulse(8'h04, 4'h8);
        `CK("vector", 12'h004, int_vector)
        rd(irqw_pkg::REG_FLAG, 8'h00);
        wr(irqw_pkg::REG_CTRL, 8'h0b);
        pulse(8'h80, 4'h2);
        pulse(8'h04, 4'h2);
        pulse(8'h02, 4'h6);
        wr(irqw_pkg::REG_TEN, 8'h04);
        pulse(8'h48, 4'h2);
        rd(irqw_pkg::REG_TFLAG, 8'h06);
        rd(irqw_pkg::REG_FLAG, 8'h07);
        pulse(8'h04, 4'h8);
        `CK("vector", 12'h004, int_vector)
        pulse(8'h01, 4'h4);
        wr(irqw_pkg::REG_CTRL, 8'h0b);
        pulse(8'h04, 4'h8);
        `CK("vector", 12'h00c, int_vector)
        rd(irqw_pkg::REG_FLAG, 8'h02);
        rd(irqw_pkg::REG_TFLAG, 8'h06);
        pulse(8'h02, 4'h6);
        wr(irqw_pkg::REG_TFLAG, 8'h00);
        rd(irqw_pkg::REG_TFLAG, 8'h00);
        wr(irqw_pkg::REG_CTRL, 8'h05);
        wr(irqw_pkg::REG_TEN, 8'h00);
        pulse(8'h04, 4'h2);
        wr(irqw_pkg::REG_TFLAG, 8'h01);
        @(posedge sys_clk) low_power <= 1'b1;
        pulse(8'h20, 4'h2);
        pulse(8'h10, 4'h3);
        @(posedge sys_clk) arst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        arst_n    <= 1'b1;
        low_power <= 1'b0;
        rd(irqw_pkg::REG_FLAG, 8'h00);
        rd(irqw_pkg::REG_TFLAG, 8'h00);
        rd(irqw_pkg::REG_EVT, 8'h00);
        `CK("irq", 1'b0, irq)
        stop_test();
    end
endmodule
`default_nettype wire
